// *** inc/dpc_regs.svh ***
`ifndef DPC_REGS_SVH
`define DPC_REGS_SVH
// Register indices; byte address is four times the index
`define DPC_IDX_MISC_CLK 8'h02
`define DPC_IDX_SYS_CTRL 8'h08
`define DPC_IDX_PIX_CTRL1 8'h10
`define DPC_IDX_PIX_SEL 8'h11
`define DPC_IDX_FIXED_REF 8'h14
`define DPC_IDX_SYS_REF 8'h15
`define DPC_IDX_SYS_FB 8'h16
`define DPC_IDX_SYS_POST 8'h17
`define DPC_IDX_SYS_RANGE 8'h18
`define DPC_IDX_B0_M 8'h20
`define DPC_IDX_B0_N 8'h21
`define DPC_IDX_B0_P 8'h22
`define DPC_IDX_B0_C 8'h23
`define DPC_IDX_B1_M 8'h24
`define DPC_IDX_B1_N 8'h25
`define DPC_IDX_B1_P 8'h26
`define DPC_IDX_B1_C 8'h27
`define DPC_IDX_B2_M 8'h28
`define DPC_IDX_B2_N 8'h29
`define DPC_IDX_B2_P 8'h30
`define DPC_IDX_B2_C 8'h31
`define DPC_IDX_B3_M 8'h32
`define DPC_IDX_B3_N 8'h33
`define DPC_IDX_B3_P 8'h34
`define DPC_IDX_B3_C 8'h35
`define DPC_IDX_RB_POST 8'h8c
`define DPC_IDX_RB_RANGE 8'h8d
`define DPC_IDX_RB_FB 8'h8e
`define DPC_IDX_RB_REF 8'h8f
`define DPC_IDX_STATUS 8'h90
// Field positions and bank source codes
`define DPC_BIT_PIX_EN 0
`define DPC_BIT_SYS_EN 0
`define DPC_BIT_SYS_PROG 4
`define DPC_SRC_PINS 3'h4
`define DPC_SRC_REG 3'h5
// Field limits
`define DPC_FB_MIN 7'h02
`define DPC_POST_MAX 3'h4
`define DPC_SYS_POST_MIN 3'h1
// Values used by the legacy system path
`define DPC_LEGACY_SYS_POST 3'h1
`define DPC_LEGACY_SYS_RANGE 2'h1
// Reset values
`define DPC_RST_MISC_CLK 8'h01
`define DPC_RST_SYS_CTRL 8'h01
`define DPC_RST_FB_RATIO 8'h03
`define DPC_RST_REF_RATIO 7'h01
`define DPC_RST_POST_RATIO 4'h1
`define DPC_RST_LEGACY 1'b1
`endif

// *** inc/dpc_pkg.sv ***
`include "dpc_regs.svh"
package dpc_pkg;
  // Where the active pixel bank comes from
  typedef enum logic [1:0] {
    DPC_SRC_LEGACY, DPC_SRC_EXT, DPC_SRC_INT
  } dpc_src_t;

  typedef struct packed {
    logic [7:0] m;
    logic [7:0] n;
    logic [7:0] p;
    logic [7:0] c;
  } dpc_bank_t;

  typedef struct packed {
    logic [7:0] misc_clk;
    logic [7:0] sys_ctrl;
    logic [7:0] pix_ctrl1;
    logic [7:0] pix_sel;
    logic [7:0] fixed_ref;
    logic [7:0] sys_ref;
    logic [7:0] sys_fb;
    logic [7:0] sys_post;
    logic [7:0] sys_range;
    dpc_bank_t [3:0] bank;
    logic [7:0] sys_fb_r;
    logic [6:0] sys_ref_r;
    logic [1:0] sys_rng;
    logic [7:0] pix_fb_r;
    logic [6:0] pix_ref_r;
    logic [1:0] pix_rng;
    logic [2:0] pix_post;
    logic [1:0] pix_bank;
    logic pix_legacy;
    logic [7:0] rdata;
  } dpc_state_t;

  typedef struct packed {
    logic [2:0] code;
    logic [3:0] ratio;
  } dpc_post_t;

  // Feedback ratio is field plus one; illegal low codes clamp up
  function automatic logic [7:0] dpc_fb_ratio(input logic [7:0] code);
    logic [6:0] m;
    m = code[6:0];
    if (m < `DPC_FB_MIN) m = `DPC_FB_MIN;
    return {1'b0, m} + 8'h01;
  endfunction : dpc_fb_ratio

  function automatic logic dpc_fb_bad(input logic [7:0] code);
    return code[7] || (code[6:0] < `DPC_FB_MIN);
  endfunction : dpc_fb_bad

  // Reference ratio is field plus one, 1 to 64
  function automatic logic [6:0] dpc_ref_ratio(input logic [7:0] code);
    return {1'b0, code[5:0]} + 7'h01;
  endfunction : dpc_ref_ratio

  // Zero divides by one, 1 to 4 twice the code; codes above 4 act as 4
  function automatic logic [3:0] dpc_post_ratio(input logic [2:0] code);
    logic [2:0] p;
    p = (code > `DPC_POST_MAX) ? `DPC_POST_MAX : code;
    return (p == 3'h0) ? 4'h1 : {p, 1'b0};
  endfunction : dpc_post_ratio
endpackage : dpc_pkg

// *** design/dpc_pin_sync.sv ***
`timescale 1ns/1ns
`default_nettype none
module dpc_pin_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Asynchronous pins in, synchronised level out
  input wire logic [WIDTH-1:0] pins,
  output logic [WIDTH-1:0] pins_sync
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } dpc_sync_t;

  dpc_sync_t q;
  dpc_sync_t d;

  // First stage feeds only the second stage
  always_comb begin
    d = q;
    d.s1 = pins;
    d.s2 = q.s1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign pins_sync = q.s2;
endmodule : dpc_pin_sync
`default_nettype wire

// *** design/dpc_post_apply.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "dpc_regs.svh"
module dpc_post_apply
  import dpc_pkg::*;
#(
  parameter bit PROTECT = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Requested code and oscillator divider boundary
  input wire logic [2:0] code_in,
  input wire logic boundary,
  // Applied code and ratio
  output logic [2:0] code_q,
  output logic [3:0] ratio_q
);
  dpc_post_t q;
  dpc_post_t d;

  // Protected path waits for the divider boundary; bare path does not
  always_comb begin
    d = q;
    if (!PROTECT || boundary) begin
      d.code = code_in;
      d.ratio = dpc_post_ratio(code_in);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q.code <= 3'h0;
      q.ratio <= `DPC_RST_POST_RATIO;
    end else begin
      q <= d;
    end
  end

  assign code_q = q.code;
  assign ratio_q = q.ratio;
endmodule : dpc_post_apply
`default_nettype wire

// *** design/dpc_pll_ctrl.sv ***
// Behaviour
// - Feedback field 2..127 legal; ratio is field plus one, 3..128.
// - Reference field 0..63; ratio is field plus one, 1..64.
// - Post field 0 divides by one, except the system field, which treats 0 as 1; 1..4 divide by twice the field.
// - Feedback or reference change alone moves output without glitch.
// - Pixel post divider change is applied unprotected and may glitch.
// - System post divider change applies on the oscillator boundary.
// - Bank switch behaves like individual field changes.
// - Program-mode one uses system reference, feedback, post, range regs.
// - Bank source 100 picks the pixel bank from the select pins.
// - Bank source 101 picks the pixel bank from bank-select bits 1:0.
// - Four pixel banks of feedback, reference, post, range values.
// - Legacy bank source 000..011 uses the fixed reference divider.
// - Read-only registers return pixel values actually in use.
// - In legacy mode post and range readback are undefined.
// - Both synthesisers enabled after reset and follow programming.
// - Disabled synthesiser ignores feedback and reference; post applies.
// - Writing zero to an enable bit disables that synthesiser.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "dpc_regs.svh"
module dpc_pll_ctrl
  import dpc_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Board bank select pins
  input wire logic [1:0] bank_select_pins,
  // System synthesiser
  input wire logic sys_vco_boundary,
  output logic sys_synth_enable,
  output logic [7:0] sys_feedback_ratio,
  output logic [6:0] sys_ref_ratio,
  output logic [3:0] sys_post_ratio,
  output logic [1:0] sys_range,
  // Pixel synthesiser
  output logic pixel_synth_enable,
  output logic [7:0] pix_feedback_ratio,
  output logic [6:0] pix_ref_ratio,
  output logic [3:0] pix_post_ratio,
  output logic [1:0] pix_range,
  output logic pix_legacy_mode
);
  // Index field needs address bits 9:2
  if (ADDR_W < 10) begin : g_chk
    $error("dpc_pll_ctrl: ADDR_W must be at least 10");
  end

  dpc_state_t q;
  dpc_state_t d;
  logic [1:0] pins_s;
  logic [2:0] pix_post_code;
  logic [2:0] sys_post_code;
  logic [3:0] pix_post_r;
  logic [3:0] sys_post_r;
  logic dec_ok;

  // Index of one bank field; bank 2 upper fields are not contiguous
  function automatic logic [7:0] bank_idx(input int b, input int f);
    logic [7:0] r;
    r = 8'h00;
    case (b * 4 + f)
      0: r = `DPC_IDX_B0_M;
      1: r = `DPC_IDX_B0_N;
      2: r = `DPC_IDX_B0_P;
      3: r = `DPC_IDX_B0_C;
      4: r = `DPC_IDX_B1_M;
      5: r = `DPC_IDX_B1_N;
      6: r = `DPC_IDX_B1_P;
      7: r = `DPC_IDX_B1_C;
      8: r = `DPC_IDX_B2_M;
      9: r = `DPC_IDX_B2_N;
      10: r = `DPC_IDX_B2_P;
      11: r = `DPC_IDX_B2_C;
      12: r = `DPC_IDX_B3_M;
      13: r = `DPC_IDX_B3_N;
      14: r = `DPC_IDX_B3_P;
      15: r = `DPC_IDX_B3_C;
      default: r = 8'h00;
    endcase
    return r;
  endfunction : bank_idx

  // One field of a bank, by field number
  function automatic logic [7:0] bank_fld(input dpc_bank_t bk,
                                          input int f);
    logic [7:0] r;
    r = 8'h00;
    case (f)
      0: r = bk.m;
      1: r = bk.n;
      2: r = bk.p;
      3: r = bk.c;
      default: r = 8'h00;
    endcase
    return r;
  endfunction : bank_fld

  // Read-only indices refuse writes
  function automatic logic is_ro(input logic [7:0] idx);
    return idx == `DPC_IDX_RB_POST || idx == `DPC_IDX_RB_RANGE ||
           idx == `DPC_IDX_RB_FB || idx == `DPC_IDX_RB_REF ||
           idx == `DPC_IDX_STATUS;
  endfunction : is_ro

  // Decoded bank source
  function automatic dpc_src_t src_of(input logic [7:0] ctrl1);
    dpc_src_t s;
    case (ctrl1[2:0])
      `DPC_SRC_PINS: s = DPC_SRC_EXT;
      `DPC_SRC_REG: s = DPC_SRC_INT;
      default: s = DPC_SRC_LEGACY;
    endcase
    return s;
  endfunction : src_of

  // Board pins are asynchronous to pclk
  dpc_pin_sync #(
    .WIDTH(2)
  ) u_pin_sync (
    .clk(pclk),
    .rst_n(presetn),
    .pins(bank_select_pins),
    .pins_sync(pins_s)
  );

  // System post divider waits for the oscillator boundary
  dpc_post_apply #(
    .PROTECT(1'b1)
  ) u_sys_post (
    .clk(pclk),
    .rst_n(presetn),
    .code_in(sys_post_code),
    .boundary(sys_vco_boundary),
    .code_q(),
    .ratio_q(sys_post_r)
  );

  // Pixel post divider has no protection by design
  dpc_post_apply #(
    .PROTECT(1'b0)
  ) u_pix_post (
    .clk(pclk),
    .rst_n(presetn),
    .code_in(pix_post_code),
    .boundary(1'b0),
    .code_q(),
    .ratio_q(pix_post_r)
  );

  // Decode, register writes, selection and read data
  always_comb begin
    logic [7:0] idx;
    logic addr_ok;
    logic mapped;
    logic wr;
    logic [7:0] wd;
    logic [7:0] rd;
    logic [1:0] sel;
    dpc_bank_t act;
    dpc_src_t src;
    logic sys_prog;
    logic [2:0] sp;
    idx = paddr[9:2];
    addr_ok = (paddr[1:0] == 2'b00);
    if (ADDR_W > 10) begin
      addr_ok = addr_ok && ((paddr >> 10) == '0);
    end
    mapped = 1'b0;
    wd = pwdata[7:0];
    rd = 8'h00;
    sel = 2'h0;
    sp = 3'h0;
    d = q;

    // Mapping check for the bus answer
    case (idx)
      `DPC_IDX_MISC_CLK, `DPC_IDX_SYS_CTRL, `DPC_IDX_PIX_CTRL1,
      `DPC_IDX_PIX_SEL, `DPC_IDX_FIXED_REF, `DPC_IDX_SYS_REF,
      `DPC_IDX_SYS_FB, `DPC_IDX_SYS_POST, `DPC_IDX_SYS_RANGE: begin
        mapped = 1'b1;
      end
      default: begin
        mapped = is_ro(idx);
      end
    endcase
    for (int b = 0; b < 4; b++) begin
      for (int f = 0; f < 4; f++) begin
        if (idx == bank_idx(b, f)) begin
          mapped = 1'b1;
        end
      end
    end
    mapped = mapped && addr_ok;

    // Writes land in the access phase; only lane 0 carries data
    wr = psel && penable && pwrite && mapped && !is_ro(idx) && pstrb[0];
    if (wr) begin
      case (idx)
        `DPC_IDX_MISC_CLK: d.misc_clk = wd;
        `DPC_IDX_SYS_CTRL: d.sys_ctrl = wd;
        `DPC_IDX_PIX_CTRL1: d.pix_ctrl1 = wd;
        `DPC_IDX_PIX_SEL: d.pix_sel = wd;
        `DPC_IDX_FIXED_REF: d.fixed_ref = wd;
        `DPC_IDX_SYS_REF: d.sys_ref = wd;
        `DPC_IDX_SYS_FB: d.sys_fb = wd;
        `DPC_IDX_SYS_POST: d.sys_post = wd;
        `DPC_IDX_SYS_RANGE: d.sys_range = wd;
        default: begin
        end
      endcase
      for (int b = 0; b < 4; b++) begin
        if (idx == bank_idx(b, 0)) d.bank[b].m = wd;
        if (idx == bank_idx(b, 1)) d.bank[b].n = wd;
        if (idx == bank_idx(b, 2)) d.bank[b].p = wd;
        if (idx == bank_idx(b, 3)) d.bank[b].c = wd;
      end
    end

    // Active pixel bank; legacy modes still follow the pins
    src = src_of(q.pix_ctrl1);
    case (src)
      DPC_SRC_EXT: sel = pins_s;
      DPC_SRC_INT: sel = q.pix_sel[1:0];
      default: sel = pins_s;
    endcase
    act = q.bank[sel];

    // Pixel values in use, recomputed every cycle so changes follow
    d.pix_bank = sel;
    d.pix_legacy = (src == DPC_SRC_LEGACY);
    d.pix_fb_r = dpc_fb_ratio(act.m);
    if (src == DPC_SRC_LEGACY) begin
      d.pix_ref_r = dpc_ref_ratio(q.fixed_ref);
      d.pix_post = 3'h0;
    end else begin
      d.pix_ref_r = dpc_ref_ratio(act.n);
      d.pix_post = act.p[2:0];
    end
    d.pix_rng = act.c[1:0];

    // System values; legacy mode ignores the post and range registers
    sys_prog = q.sys_ctrl[`DPC_BIT_SYS_PROG];
    d.sys_fb_r = dpc_fb_ratio(q.sys_fb);
    d.sys_ref_r = dpc_ref_ratio(q.sys_ref);
    if (sys_prog) begin
      sp = q.sys_post[2:0];
      // Zero is not a system ratio; treat it as the smallest legal code
      if (sp < `DPC_SYS_POST_MIN) sp = `DPC_SYS_POST_MIN;
      d.sys_rng = q.sys_range[1:0];
    end else begin
      sp = `DPC_LEGACY_SYS_POST;
      d.sys_rng = `DPC_LEGACY_SYS_RANGE;
    end
    sys_post_code = sp;
    pix_post_code = q.pix_post;

    // Read data registered in setup so it stands through access
    case (idx)
      `DPC_IDX_MISC_CLK: rd = q.misc_clk;
      `DPC_IDX_SYS_CTRL: rd = q.sys_ctrl;
      `DPC_IDX_PIX_CTRL1: rd = q.pix_ctrl1;
      `DPC_IDX_PIX_SEL: rd = q.pix_sel;
      `DPC_IDX_FIXED_REF: rd = q.fixed_ref;
      `DPC_IDX_SYS_REF: rd = q.sys_ref;
      `DPC_IDX_SYS_FB: rd = q.sys_fb;
      `DPC_IDX_SYS_POST: rd = q.sys_post;
      `DPC_IDX_SYS_RANGE: rd = q.sys_range;
      `DPC_IDX_RB_FB: rd = q.pix_fb_r - 8'h01;
      `DPC_IDX_RB_REF: rd = {1'b0, q.pix_ref_r - 7'h01};
      // Undefined in legacy mode; shown as zero there
      `DPC_IDX_RB_POST: rd = q.pix_legacy ? 8'h00 :
                              {5'h00, q.pix_post};
      `DPC_IDX_RB_RANGE: rd = q.pix_legacy ? 8'h00 :
                               {6'h00, q.pix_rng};
      `DPC_IDX_STATUS: rd = {1'b0, q.pix_legacy, q.pix_bank,
                             q.sys_post[2:0] == 3'h0,
                             q.sys_post[2:0] > `DPC_POST_MAX,
                             dpc_fb_bad(q.sys_fb),
                             dpc_fb_bad(q.bank[q.pix_bank].m)};
      default: rd = 8'h00;
    endcase
    for (int b = 0; b < 4; b++) begin
      for (int f = 0; f < 4; f++) begin
        if (idx == bank_idx(b, f)) rd = bank_fld(q.bank[b], f);
      end
    end
    if (psel && !penable) begin
      d.rdata = (mapped && !pwrite) ? rd : 8'h00;
    end
  end

  // Enables, in-use ratios and legacy flag load reset values; other registers clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.misc_clk <= `DPC_RST_MISC_CLK;
      q.sys_ctrl <= `DPC_RST_SYS_CTRL;
      q.sys_fb_r <= `DPC_RST_FB_RATIO;
      q.sys_ref_r <= `DPC_RST_REF_RATIO;
      q.pix_fb_r <= `DPC_RST_FB_RATIO;
      q.pix_ref_r <= `DPC_RST_REF_RATIO;
      q.pix_legacy <= `DPC_RST_LEGACY;
    end else begin
      q <= d;
    end
  end

  // Zero-wait bus answer; errors for misaligned or unmapped accesses and read-only writes
  assign pready = 1'b1;
  assign pslverr = psel && penable &&
                   (!(paddr[1:0] == 2'b00 &&
                      (ADDR_W <= 10 || (paddr >> 10) == '0)) ||
                    !dec_ok || (pwrite && is_ro(paddr[9:2])));
  assign prdata = {24'h000000, q.rdata};

  // Enable straight from its bit; a disabled loop ignores M and N
  assign sys_synth_enable = q.sys_ctrl[`DPC_BIT_SYS_EN];
  assign pixel_synth_enable = q.misc_clk[`DPC_BIT_PIX_EN];
  assign sys_feedback_ratio = q.sys_fb_r;
  assign sys_ref_ratio = q.sys_ref_r;
  // Post ratio is never gated by enable
  assign sys_post_ratio = sys_post_r;
  assign sys_range = q.sys_rng;
  assign pix_feedback_ratio = q.pix_fb_r;
  assign pix_ref_ratio = q.pix_ref_r;
  assign pix_post_ratio = pix_post_r;
  assign pix_range = q.pix_rng;
  assign pix_legacy_mode = q.pix_legacy;

  // Mapping seen by the error answer, same decode as above
  always_comb begin
    dec_ok = is_ro(paddr[9:2]);
    case (paddr[9:2])
      `DPC_IDX_MISC_CLK, `DPC_IDX_SYS_CTRL, `DPC_IDX_PIX_CTRL1,
      `DPC_IDX_PIX_SEL, `DPC_IDX_FIXED_REF, `DPC_IDX_SYS_REF,
      `DPC_IDX_SYS_FB, `DPC_IDX_SYS_POST, `DPC_IDX_SYS_RANGE: begin
        dec_ok = 1'b1;
      end
      default: begin
      end
    endcase
    for (int b = 0; b < 4; b++) begin
      for (int f = 0; f < 4; f++) begin
        if (paddr[9:2] == bank_idx(b, f)) dec_ok = 1'b1;
      end
    end
  end
endmodule : dpc_pll_ctrl
`default_nettype wire

// *** design/dummy_unused.sv ***
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// *** bench/dpc_pll_ctrl_monitor.sv ***
`timescale 1ns/1ns
`default_nettype none
module dpc_pll_ctrl_monitor #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // Synthesiser controls
  input wire logic sys_vco_boundary,
  input wire logic [6:0] sys_ref_ratio,
  input wire logic [3:0] sys_post_ratio,
  input wire logic pixel_synth_enable,
  input wire logic [7:0] pix_feedback_ratio,
  input wire logic [6:0] pix_ref_ratio,
  input wire logic [3:0] pix_post_ratio,
  input wire logic pix_legacy_mode
);
  logic acc_wr;
  logic wr_misc_off;
  logic wr_ctrl1;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Committed writes that may move the mode and pixel enable outputs
  assign acc_wr = psel && penable && pwrite && pstrb[0];
  assign wr_misc_off = acc_wr && paddr == ADDR_W'(12'h008) && !pwdata[0];
  assign wr_ctrl1 = acc_wr && paddr == ADDR_W'(12'h040);

  a_fb_range: assert property (
    pix_feedback_ratio inside {[8'h03:8'h80]})
    else $error("pixel feedback ratio out of range");
  a_ref_range: assert property (
    pix_ref_ratio inside {[7'h01:7'h40]} && sys_ref_ratio inside {[7'h01:7'h40]})
    else $error("reference ratio out of range");
  a_post_codes: assert property (
    pix_post_ratio inside {4'h1, 4'h2, 4'h4, 4'h6, 4'h8})
    else $error("pixel post ratio not a legal division");
  // Boundary may be registered once before use, hence two depths
  a_sys_post_sync: assert property (
    !$stable(sys_post_ratio) |-> $past(sys_vco_boundary) || $past(sys_vco_boundary, 2))
    else $error("system post ratio moved off the oscillator boundary");
  a_mode_cause: assert property (
    $changed(pix_legacy_mode) |-> $past(wr_ctrl1) || $past(wr_ctrl1, 2))
    else $error("legacy mode changed without a control write");
  a_pix_disable: assert property (
    $fell(pixel_synth_enable) |-> $past(wr_misc_off) || $past(wr_misc_off, 2))
    else $error("pixel synthesiser disabled without a write of zero");
  a_ro_refused: assert property (
    psel && penable && pwrite && paddr == ADDR_W'(12'h230) |-> pslverr)
    else $error("write to readback register not refused");
  a_fb_readback: assert property (
    psel && penable && !pwrite && paddr == ADDR_W'(12'h238) && $stable(pix_feedback_ratio)
      && pix_feedback_ratio == $past(pix_feedback_ratio, 3)
      |-> prdata == {24'h0, pix_feedback_ratio - 8'h01})
    else $error("feedback readback differs from value in use");
endmodule : dpc_pll_ctrl_monitor

bind dpc_pll_ctrl dpc_pll_ctrl_monitor #(.ADDR_W(ADDR_W)) dpc_pll_ctrl_monitor_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pslverr(pslverr), .sys_vco_boundary(sys_vco_boundary),
  .sys_ref_ratio(sys_ref_ratio), .sys_post_ratio(sys_post_ratio),
  .pixel_synth_enable(pixel_synth_enable),
  .pix_feedback_ratio(pix_feedback_ratio), .pix_ref_ratio(pix_ref_ratio),
  .pix_post_ratio(pix_post_ratio), .pix_legacy_mode(pix_legacy_mode)
);
`default_nettype wire

// *** bench/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic sys_vco_boundary, sys_synth_enable, pixel_synth_enable, pix_legacy_mode;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb, sys_post_ratio, pix_post_ratio;
  logic [1:0] bank_select_pins, sys_range, pix_range;
  logic [7:0] sys_feedback_ratio, pix_feedback_ratio;
  logic [6:0] sys_ref_ratio, pix_ref_ratio;
  int failures, comparisons;

  dpc_pll_ctrl #(.ADDR_W(12)) dpc_pll_ctrl_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bank_select_pins(bank_select_pins), .sys_vco_boundary(sys_vco_boundary),
    .sys_synth_enable(sys_synth_enable), .sys_feedback_ratio(sys_feedback_ratio),
    .sys_ref_ratio(sys_ref_ratio), .sys_post_ratio(sys_post_ratio),
    .sys_range(sys_range), .pixel_synth_enable(pixel_synth_enable),
    .pix_feedback_ratio(pix_feedback_ratio), .pix_ref_ratio(pix_ref_ratio),
    .pix_post_ratio(pix_post_ratio), .pix_range(pix_range),
    .pix_legacy_mode(pix_legacy_mode)
  );

  // 10 MHz clock
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task report_and_stop;
    if (failures == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop

  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One APB transfer; request held until pready is seen high
  task apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
           input logic [3:0] st);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, wd};
    pstrb <= st;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task w(input logic [7:0] idx, input logic [7:0] val);
    apb(1'b1, idx, val, 4'hf);
  endtask : w

  task r(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00, 4'hf);
    check(rd, {24'h0, exp});
  endtask : r

  task waitc(input int n);
    repeat (n) @(posedge pclk);
  endtask : waitc

  task pulse;
    @(posedge pclk);
    sys_vco_boundary <= 1'b1;
    @(posedge pclk);
    sys_vco_boundary <= 1'b0;
  endtask : pulse

  // Bank 2 post and range sit at 0x30 and 0x31, not in line
  function automatic logic [7:0] bidx(input int b, input int f);
    if (b == 2 && f > 1) return 8'(8'h2e + f);
    return 8'((b == 3 ? 8'h32 : 8'h20 + 4 * b) + f);
  endfunction : bidx

  task t_reset;
    check(sys_synth_enable, 1'b1);
    check(pixel_synth_enable, 1'b1);
    check(pix_feedback_ratio, 8'h03);
    check(pix_legacy_mode, 1'b1);
    r(8'h02, 8'h01);
    r(8'h08, 8'h01);
  endtask : t_reset

  task t_sys;
    w(8'h15, 8'h05);
    w(8'h16, 8'h40);
    w(8'h17, 8'h03);
    w(8'h18, 8'h02);
    pulse;
    waitc(3);
    check(sys_feedback_ratio, 8'h41);
    check(sys_ref_ratio, 7'h06);
    check(sys_post_ratio, 4'h2);
    check(sys_range, 2'h1);
    w(8'h08, 8'h11);
    waitc(3);
    check(sys_post_ratio, 4'h2);
    pulse;
    waitc(3);
    check(sys_post_ratio, 4'h6);
    check(sys_range, 2'h2);
    w(8'h17, 8'h04);
    pulse;
    waitc(3);
    check(sys_post_ratio, 4'h8);
    w(8'h16, 8'h7f);
    w(8'h15, 8'h3f);
    waitc(3);
    check(sys_feedback_ratio, 8'h80);
    check(sys_ref_ratio, 7'h40);
  endtask : t_sys

  task t_banks;
    w(8'h10, 8'h05);
    for (int b = 0; b < 4; b++) begin
      w(bidx(b, 0), 8'(8'h20 + b));
      w(bidx(b, 1), 8'(b));
      w(bidx(b, 2), 8'(b));
      w(bidx(b, 3), b[0] ? 8'h02 : 8'h01);
    end
    for (int b = 0; b < 4; b++) begin
      w(8'h11, 8'(b));
      waitc(3);
      check(pix_feedback_ratio, 8'h21 + b);
      check(pix_ref_ratio, b + 1);
      check(pix_post_ratio, b == 0 ? 1 : 2 * b);
      check(pix_range, b[0] ? 2 : 1);
      r(8'h8e, 8'(8'h20 + b));
      r(8'h8f, 8'(b));
      r(8'h8c, 8'(b));
      r(8'h8d, b[0] ? 8'h02 : 8'h01);
    end
    w(bidx(3, 2), 8'h04);
    waitc(3);
    check(pix_post_ratio, 4'h8);
  endtask : t_banks

  // Pins are asynchronous; output must lag by the synchroniser
  task t_pins;
    w(8'h10, 8'h04);
    waitc(4);
    check(pix_feedback_ratio, 8'h21);
    for (int b = 1; b < 4; b++) begin
      @(posedge pclk);
      bank_select_pins <= 2'(b);
      waitc(2);
      check(pix_feedback_ratio, 8'h20 + b);
      waitc(4);
      check(pix_feedback_ratio, 8'h21 + b);
    end
  endtask : t_pins

  task t_legacy;
    w(8'h14, 8'h07);
    w(8'h10, 8'h00);
    waitc(3);
    check(pix_legacy_mode, 1'b1);
    check(pix_ref_ratio, 7'h08);
    w(8'h10, 8'h05);
    waitc(3);
    check(pix_ref_ratio, 7'h04);
    check(pix_legacy_mode, 1'b0);
  endtask : t_legacy

  task t_disable;
    w(8'h02, 8'h00);
    waitc(3);
    check(pixel_synth_enable, 1'b0);
    check(pix_post_ratio, 4'h8);
    w(8'h08, 8'h10);
    waitc(3);
    check(sys_synth_enable, 1'b0);
    check(sys_post_ratio, 4'h8);
    w(8'h02, 8'h01);
    w(8'h08, 8'h11);
    waitc(3);
    check(pixel_synth_enable, 1'b1);
  endtask : t_disable

  task t_refuse;
    apb(1'b1, 8'h8c, 8'h55, 4'hf);
    check(err, 1'b1);
    r(8'h8c, 8'h04);
    apb(1'b0, 8'h50, 8'h00, 4'hf);
    check(err, 1'b1);
    check(rd, 32'h0);
    apb(1'b1, 8'h11, 8'h00, 4'h0);
    r(8'h11, 8'h03);
  endtask : t_refuse

  // Main sequence after a 12 cycle reset
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    bank_select_pins = 2'h0;
    sys_vco_boundary = 1'b0;
    failures = 0;
    comparisons = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    waitc(2);
    t_reset;
    t_sys;
    t_banks;
    t_pins;
    t_legacy;
    t_disable;
    t_refuse;
    report_and_stop;
  end

  // Watchdog, far beyond the few hundred cycles needed
  initial begin
    #(100 * 20000);
    failures++;
    report_and_stop;
  end
endmodule : tb_top
`default_nettype wire
